// ==== include/scsw_pkg.sv ====
// ----------------------------------------
// switch control constants
// ----------------------------------------
package scsw_pkg;

  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned HZ_PER_KHZ      = 1000;
  localparam int unsigned AUTH_OFF_MIN_MS = 1000;
  // least off time, rounded down to whole cycles
  localparam int unsigned AUTH_OFF_MIN_CYCLES =
    ((CLK_HZ / HZ_PER_KHZ) * AUTH_OFF_MIN_MS);

  localparam int unsigned NUM_CH_DEF = 4;
  localparam int unsigned KB_W_DEF   = 8;
  localparam int unsigned CNT_W      = 32;

  localparam int unsigned SEL_CH_RST   = 0;
  localparam logic        AUTH_PWR_RST = 1'b1;

  typedef enum logic [1:0] {
    SCSW_MECH_BUTTON = 2'b00,
    SCSW_MECH_TOUCH  = 2'b01,
    SCSW_MECH_MOUSE  = 2'b10,
    SCSW_MECH_NONE   = 2'b11
  } scsw_mech_t;

  typedef enum logic [1:0] {
    SCSW_IDLE     = 2'b00,
    SCSW_PURGE    = 2'b01,
    SCSW_AUTH_OFF = 2'b10
  } scsw_state_t;

endpackage

// ==== design/scsw_ctrl.sv ====
// Behaviour
// RULE1: channel change power-cycles auth port, off >=1s
// RULE2: no power cycle when auth function emulated
// RULE3: off interval may be set longer
// RULE4: user data held only in volatile flops
// RULE5: configuration may persist, kept outside block
// RULE6: channel change clears pending keyboard words
// RULE7: purge after select, before new transfers
// RULE8: change channel only on authorized request
// RULE9: buttons, touch screen, mouse are authorized
// RULE10: no hotkey, scan or voice switching
// RULE11: exactly one mechanism enabled; others ignored; code also allows none (SCSW_MECH_NONE)
// RULE12: no computer path controls the switch
// RULE13: off time counted from clock, never below 1s
`timescale 1ns/1ps

module scsw_ctrl #(
  parameter int unsigned NUM_CH              = scsw_pkg::NUM_CH_DEF,
  parameter int unsigned CH_W                = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
  parameter int unsigned KB_W                = scsw_pkg::KB_W_DEF,
  parameter int unsigned AUTH_OFF_MIN_CYCLES = scsw_pkg::AUTH_OFF_MIN_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [NUM_CH-1:0]          button_press,
  input  wire logic [1:0]                 mech_sel,
  input  wire logic                       touch_req_valid,
  input  wire logic [CH_W-1:0]            touch_req_ch,
  input  wire logic                       mouse_req_valid,
  input  wire logic [CH_W-1:0]            mouse_req_ch,
  input  wire logic                       auth_emulated,
  input  wire logic [scsw_pkg::CNT_W-1:0] auth_off_cfg,
  input  wire logic                       kb_in_valid,
  input  wire logic [KB_W-1:0]            kb_in_data,
  output logic                            kb_in_ready,
  output logic                            kb_out_valid,
  output logic [KB_W-1:0]                 kb_out_data,
  input  wire logic                       kb_out_ready,
  output logic [CH_W-1:0]                 sel_ch,
  output logic                            auth_pwr_en,
  output logic                            switch_busy
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [scsw_pkg::CNT_W-1:0] OFF_MIN =
    scsw_pkg::CNT_W'(AUTH_OFF_MIN_CYCLES);
  localparam logic [CH_W:0] CH_LIMIT = (CH_W + 1)'(NUM_CH);
  localparam logic [CH_W-1:0] SEL_RST = CH_W'(scsw_pkg::SEL_CH_RST);

  // button pipeline, one bit per channel
  logic [NUM_CH-1:0]          btn_meta;
  logic [NUM_CH-1:0]          btn_sync;
  logic [NUM_CH-1:0]          btn_prev;
  logic [NUM_CH-1:0]          next_btn_meta;
  logic [NUM_CH-1:0]          next_btn_sync;
  logic [NUM_CH-1:0]          next_btn_prev;
  logic [NUM_CH-1:0]          btn_rise;
  logic                       btn_hit;
  logic [CH_W-1:0]            btn_ch;

  // request path
  logic                       req_valid;
  logic [CH_W-1:0]            req_ch;
  logic                       req_in_range;
  logic                       req_new_ch;
  logic                       seq_idle;
  logic                       req_ok;
  logic [scsw_pkg::CNT_W-1:0] off_load;

  // switch, timer and keyboard hold state
  scsw_pkg::scsw_state_t      state;
  scsw_pkg::scsw_state_t      next_state;
  logic [CH_W-1:0]            next_sel_ch;
  logic [scsw_pkg::CNT_W-1:0] off_cnt;
  logic [scsw_pkg::CNT_W-1:0] next_off_cnt;
  logic                       off_done;
  logic                       next_auth_pwr_en;
  logic                       hold_valid;
  logic                       next_hold_valid;
  logic [KB_W-1:0]            next_kb_out_data;

  // ----------------------------------------
  // front-panel button synchroniser
  // ----------------------------------------
  // two flops per pin, a third for the edge
  for (genvar g = 0; g < NUM_CH; g++) begin : g_btn
    always_comb begin
      next_btn_meta[g] = button_press[g];
      next_btn_sync[g] = btn_meta[g];
      next_btn_prev[g] = btn_sync[g];
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        btn_meta[g] <= 1'b0;
        btn_sync[g] <= 1'b0;
        btn_prev[g] <= 1'b0;
      end else begin
        btn_meta[g] <= next_btn_meta[g];
        btn_sync[g] <= next_btn_sync[g];
        btn_prev[g] <= next_btn_prev[g];
      end
    end

    // press seen as a rising edge
    assign btn_rise[g] = btn_sync[g] & ~btn_prev[g];
  end

  // lowest newly pressed button wins
  always_comb begin
    btn_hit = 1'b0;
    btn_ch  = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (btn_rise[i]) begin
        btn_hit = 1'b1;
        btn_ch  = CH_W'(i);
      end
    end
  end

  // ----------------------------------------
  // request source selection
  // ----------------------------------------
  // only physical-touch sources have ports at all
  always_comb begin
    req_valid = 1'b0; // RULE10
    req_ch    = '0;
    unique case (scsw_pkg::scsw_mech_t'(mech_sel)) // RULE11
      scsw_pkg::SCSW_MECH_BUTTON: begin
        req_valid = btn_hit; // RULE9
        req_ch    = btn_ch;
      end
      scsw_pkg::SCSW_MECH_TOUCH: begin
        req_valid = touch_req_valid; // RULE9
        req_ch    = touch_req_ch;
      end
      scsw_pkg::SCSW_MECH_MOUSE: begin
        req_valid = mouse_req_valid; // RULE9
        req_ch    = mouse_req_ch;
      end
      scsw_pkg::SCSW_MECH_NONE: begin
        req_valid = 1'b0;
        req_ch    = '0;
      end
    endcase
  end

  // ----------------------------------------
  // request qualification
  // ----------------------------------------
  // channel must exist and differ from the current one
  assign req_in_range = ({1'b0, req_ch} < CH_LIMIT);
  assign req_new_ch   = (req_ch != sel_ch);
  // requests during a running switch are dropped, not queued
  assign seq_idle     = (state == scsw_pkg::SCSW_IDLE);

  // no keyboard or host input reaches this decision
  assign req_ok = req_valid // RULE8
                  && req_in_range
                  && req_new_ch
                  && seq_idle; // RULE12

  // ----------------------------------------
  // off time setting
  // ----------------------------------------
  // setting lives outside; clamped to the least time
  assign off_load = (auth_off_cfg > OFF_MIN) ? auth_off_cfg : OFF_MIN; // RULE3 RULE5

  // ----------------------------------------
  // keyboard handshake
  // ----------------------------------------
  // no word moves either way while the purge runs
  assign kb_in_ready  = !hold_valid && (state != scsw_pkg::SCSW_PURGE);
  assign kb_out_valid = hold_valid && (state != scsw_pkg::SCSW_PURGE); // RULE7
  assign switch_busy  = !seq_idle;

  // ----------------------------------------
  // keyboard hold register
  // ----------------------------------------
  // one word deep; a word caught by a switch is dropped
  always_comb begin
    next_hold_valid  = hold_valid;
    next_kb_out_data = kb_out_data;

    if (kb_out_valid && kb_out_ready) begin
      next_hold_valid = 1'b0;
    end
    if (kb_in_valid && kb_in_ready) begin
      next_hold_valid  = 1'b1;
      next_kb_out_data = kb_in_data;
    end

    // selection already moved; drop stale word
    if (state == scsw_pkg::SCSW_PURGE) begin
      next_hold_valid  = 1'b0; // RULE6
      next_kb_out_data = '0; // RULE4
    end
  end

  // user data sits only in flops, gone with power
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_valid  <= 1'b0;
      kb_out_data <= '0; // RULE4
    end else begin
      hold_valid  <= next_hold_valid;
      kb_out_data <= next_kb_out_data;
    end
  end

  // ----------------------------------------
  // switch sequence
  // ----------------------------------------
  always_comb begin
    next_state  = state;
    next_sel_ch = sel_ch;

    unique case (state)
      scsw_pkg::SCSW_IDLE: begin
        if (req_ok) begin
          next_sel_ch = req_ch; // RULE8
          next_state  = scsw_pkg::SCSW_PURGE;
        end
      end
      scsw_pkg::SCSW_PURGE: begin
        // emulated auth function keeps its power
        if (auth_emulated) begin
          next_state = scsw_pkg::SCSW_IDLE; // RULE2
        end else begin
          next_state = scsw_pkg::SCSW_AUTH_OFF;
        end
      end
      scsw_pkg::SCSW_AUTH_OFF: begin
        if (off_done) begin
          next_state = scsw_pkg::SCSW_IDLE;
        end
      end
      default: begin
        next_state = scsw_pkg::SCSW_IDLE;
      end
    endcase
  end

  // switch state volatile, cleared by reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state  <= scsw_pkg::SCSW_IDLE;
      sel_ch <= SEL_RST;
    end else begin
      state  <= next_state;
      sel_ch <= next_sel_ch;
    end
  end

  // ----------------------------------------
  // auth port power timer
  // ----------------------------------------
  // counter holds the cycles still to run with power off
  assign off_done = (off_cnt == '0);

  always_comb begin
    next_off_cnt     = off_cnt;
    next_auth_pwr_en = auth_pwr_en;

    unique case (state)
      scsw_pkg::SCSW_IDLE: begin
        next_off_cnt = '0;
      end
      scsw_pkg::SCSW_PURGE: begin
        if (!auth_emulated) begin
          next_auth_pwr_en = 1'b0; // RULE1
          next_off_cnt     = off_load - 1'b1; // RULE13
        end
      end
      scsw_pkg::SCSW_AUTH_OFF: begin
        // power returns in the cycle the switch ends
        if (off_done) begin
          next_auth_pwr_en = 1'b1; // RULE1
        end else begin
          next_off_cnt = off_cnt - 1'b1; // RULE13
        end
      end
      default: begin
        next_off_cnt     = '0;
        next_auth_pwr_en = 1'b1;
      end
    endcase
  end

  // off count loaded fresh per switch, never kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      off_cnt     <= '0;
      auth_pwr_en <= scsw_pkg::AUTH_PWR_RST;
    end else begin
      off_cnt     <= next_off_cnt;
      auth_pwr_en <= next_auth_pwr_en;
    end
  end

endmodule

// ==== tb/scsw_ctrl_checker.sv ====
`timescale 1ns/1ps
module scsw_checker #(
  parameter int unsigned AUTH_OFF_MIN_CYCLES = 16
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [1:0]  mech_sel,
  input wire logic        touch_req_valid,
  input wire logic [1:0]  touch_req_ch,
  input wire logic        mouse_req_valid,
  input wire logic [1:0]  mouse_req_ch,
  input wire logic        auth_emulated,
  input wire logic [31:0] auth_off_cfg,
  input wire logic        kb_in_ready,
  input wire logic        kb_out_valid,
  input wire logic [7:0]  kb_out_data,
  input wire logic [1:0]  sel_ch,
  input wire logic        auth_pwr_en,
  input wire logic        switch_busy
);
  logic [31:0] off_cnt;
  logic [31:0] off_len;
  assign off_len = (auth_off_cfg > AUTH_OFF_MIN_CYCLES) ? auth_off_cfg : AUTH_OFF_MIN_CYCLES;
  always_ff @(posedge clk) begin
    off_cnt <= (sys_rst || auth_pwr_en) ? 32'h0000_0000 : off_cnt + 32'h0000_0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_chg_pwr_off: assert property ($changed(sel_ch) && !auth_emulated |-> switch_busy ##1 !auth_pwr_en)
    else $error("no power off after switch");
  a_emul_keep_pwr: assert property ($changed(sel_ch) && auth_emulated |-> auth_pwr_en ##1 auth_pwr_en && !switch_busy)
    else $error("power cycled while emulated");
  a_off_exact: assert property ($rose(auth_pwr_en) |-> off_cnt == off_len && $fell(switch_busy))
    else $error("wrong power off length");
  a_off_bound: assert property (!auth_pwr_en |-> off_cnt < off_len)
    else $error("power off too long");
  a_purge_hold: assert property ($changed(sel_ch) |-> !kb_out_valid && !kb_in_ready ##1 kb_out_data == 8'h00)
    else $error("keyboard word not purged");
  a_none_mech: assert property ($changed(sel_ch) |-> $past(mech_sel) != 2'h3 && !$past(switch_busy))
    else $error("switch with no mechanism");
  a_touch_src: assert property ($changed(sel_ch) && $past(mech_sel) == 2'h1 |->
    $past(touch_req_valid) && sel_ch == $past(touch_req_ch))
    else $error("switch not from touch");
  a_mouse_src: assert property ($changed(sel_ch) && $past(mech_sel) == 2'h2 |->
    $past(mouse_req_valid) && sel_ch == $past(mouse_req_ch))
    else $error("switch not from mouse");
  c_pwr_back: cover property ($rose(auth_pwr_en));
  c_emul_sw: cover property ($changed(sel_ch) && auth_emulated);
  c_kb_out: cover property (kb_out_valid);
endmodule
bind scsw_ctrl scsw_checker #(.AUTH_OFF_MIN_CYCLES(AUTH_OFF_MIN_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .mech_sel(mech_sel), .touch_req_valid(touch_req_valid),
  .touch_req_ch(touch_req_ch), .mouse_req_valid(mouse_req_valid), .mouse_req_ch(mouse_req_ch),
  .auth_emulated(auth_emulated), .auth_off_cfg(auth_off_cfg), .kb_in_ready(kb_in_ready),
  .kb_out_valid(kb_out_valid), .kb_out_data(kb_out_data), .sel_ch(sel_ch),
  .auth_pwr_en(auth_pwr_en), .switch_busy(switch_busy)
);

// ==== tb/scsw_host_model.sv ====
`timescale 1ns/1ps
module scsw_host_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       kb_out_valid,
  input  wire logic [7:0] kb_out_data,
  input  wire logic [1:0] sel_ch,
  output logic            kb_out_ready,
  output logic [9:0]      rx
);
  // stalled host withholds ready; rx keeps channel and word taken last
  assign kb_out_ready = !stall;
  always @(posedge clk) begin
    if (kb_out_valid && kb_out_ready) rx <= {sel_ch, kb_out_data};
  end
endmodule

// ==== tb/scsw_ctrl_bench.sv ====
`timescale 1ns/1ps
module scsw_ctrl_bench;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [3:0]  button_press = 4'h0;
  logic [1:0]  mech_sel = 2'h0;
  logic        tv = 1'h0;
  logic        mv = 1'h0;
  logic [1:0]  ch = 2'h0;
  logic        emul = 1'h0;
  logic [31:0] cfg = 32'h0000_0000;
  logic        kiv = 1'h0;
  logic [7:0]  kid = 8'h00;
  logic        stall = 1'h0;
  logic        kir, kov, kor, pwr, busy;
  logic [7:0]  kod;
  logic [1:0]  sel;
  logic [9:0]  rx;
  int          off_n = 0;
  int          n_mismatch = 0;
  int          checks = 0;
  scsw_ctrl #(.AUTH_OFF_MIN_CYCLES(16)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .button_press(button_press), .mech_sel(mech_sel),
    .touch_req_valid(tv), .touch_req_ch(ch), .mouse_req_valid(mv), .mouse_req_ch(ch),
    .auth_emulated(emul), .auth_off_cfg(cfg), .kb_in_valid(kiv), .kb_in_data(kid),
    .kb_in_ready(kir), .kb_out_valid(kov), .kb_out_data(kod), .kb_out_ready(kor),
    .sel_ch(sel), .auth_pwr_en(pwr), .switch_busy(busy));
  scsw_host_model u_host (.clk(clk), .stall(stall), .kb_out_valid(kov), .kb_out_data(kod),
    .sel_ch(sel), .kb_out_ready(kor), .rx(rx));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (pwr === 1'h0) off_n++;
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // src 0 button, 1 touch, 2 mouse, 3 all at once
  task automatic req(logic [1:0] src, logic [1:0] c);
    ch = c;
    tv = src[0];
    mv = src[1];
    button_press[c] = src[0] ~^ src[1];
    step(1);
    tv = 1'h0;
    mv = 1'h0;
    step(4);
    button_press = 4'h0;
    for (int i = 0; i < 100 && busy !== 1'h0; i++) step(1);
    if (busy !== 1'h0) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic send(logic [7:0] d);
    kid = d;
    kiv = 1'h1;
    step(1);
    kiv = 1'h0;
    step(3);
  endtask
  task automatic t_sources();
    check(32'(pwr), 32'h1);
    mech_sel = 2'h1;
    off_n = 0;
    req(2'h1, 2'h2);
    check(32'(sel), 32'h2);
    check(32'(off_n), 32'h10);
    req(2'h2, 2'h3);
    check(32'(sel), 32'h2);
    mech_sel = 2'h2;
    cfg = 32'h0000_0028;
    off_n = 0;
    req(2'h2, 2'h1);
    check(32'(off_n), 32'h28);
    check(32'(sel), 32'h1);
    mech_sel = 2'h0;
    emul = 1'h1;
    off_n = 0;
    req(2'h0, 2'h3);
    check(32'(sel), 32'h3);
    check(32'(off_n), 32'h0);
    emul = 1'h0;
    mech_sel = 2'h3;
    req(2'h3, 2'h0);
    check(32'(sel), 32'h3);
    $display("source test done");
  endtask
  task automatic t_purge();
    mech_sel = 2'h1;
    send(8'h11);
    stall = 1'h1;
    send(8'hA5);
    check(32'(kov), 32'h1);
    req(2'h1, 2'h0);
    check(32'(kod), 32'h0);
    stall = 1'h0;
    step(4);
    check(32'(rx), 32'h0000_0311);
    send(8'h3C);
    check(32'(rx), 32'h0000_003C);
    $display("purge test done");
  endtask
  initial begin
    step(16);
    sys_rst = 1'h0;
    step(2);
    t_sources();
    t_purge();
    conclude();
  end
endmodule
